// ===== retire_sel_pkg.sv
// constants shared by the retirement event selector and its helpers
// assumes one core clock; all offsets are byte addresses on a 32-bit register port
package retire_sel_pkg;

  // ---------------------------------------------------------------
  // register port geometry and map
  // ---------------------------------------------------------------
  localparam int unsigned REG_W        = 32;
  localparam int unsigned ADDR_W       = 8;
  localparam int unsigned NUM_CFG      = 4;
  localparam int unsigned NUM_CNT      = 6;
  localparam int unsigned FIRST_CNT_NO = 12;
  localparam logic [7:0]  OFS_CFG_BASE = 8'h00;
  localparam logic [7:0]  OFS_CTL_BASE = 8'h10;
  localparam logic [7:0]  OFS_STATUS   = 8'h28;
  localparam logic [7:0]  REG_STRIDE   = 8'h04;
  localparam logic [31:0] CFG_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTL_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CODE_HI  = 31;
  localparam int unsigned CODE_LO  = 25;
  localparam int unsigned MASK_HI  = 24;
  localparam int unsigned MASK_LO  = 9;
  localparam int unsigned SEL_HI   = 15;
  localparam int unsigned SEL_LO   = 13;
  localparam int unsigned EN_BIT   = 12;
  localparam int unsigned PAIR_BIT = 16;
  localparam int unsigned EDGE_BIT = 24;
  localparam int unsigned STAT_CLEARING_BIT = 8;

  // ---------------------------------------------------------------
  // event codes, select codes, mask bits
  // ---------------------------------------------------------------
  localparam logic [6:0] CODE_TAG     = 7'h02;
  localparam logic [6:0] CODE_FLUSH   = 7'h02;
  localparam logic [6:0] CODE_MISPRED = 7'h03;
  localparam logic [6:0] CODE_FP      = 7'h03;
  localparam logic [6:0] CODE_BRANCH  = 7'h06;
  localparam logic [6:0] CODE_INSTR   = 7'h07;
  localparam logic [2:0] SEL_TAG      = 3'h2;
  localparam logic [2:0] SEL_RET4     = 3'h4;
  localparam logic [2:0] SEL_RET5     = 3'h5;
  localparam int unsigned MB_MARK_LOAD   = 1;
  localparam int unsigned MB_MARK_STORE  = 2;
  localparam int unsigned MB_NT_PRED     = 0;
  localparam int unsigned MB_NT_MISPRED  = 1;
  localparam int unsigned MB_TK_PRED     = 2;
  localparam int unsigned MB_TK_MISPRED  = 3;
  localparam int unsigned MB_VALID_PATH  = 0;
  localparam int unsigned MB_BOGUS_PATH  = 1;
  localparam int unsigned MB_FP_LO       = 0;
  localparam int unsigned MB_FP_HI       = 4;
  localparam int unsigned MB_FLUSH_ANY   = 0;
  localparam int unsigned MB_FLUSH_MEM   = 2;
  localparam int unsigned MB_FLUSH_SMC   = 6;

  // counters 14, 15 and 17 hang on the second register of a pair
  localparam logic [5:0]  SECOND_OF_PAIR   = 6'h2C;
  localparam int unsigned CNT_W            = 2;
  localparam int unsigned AMT_W            = 3;
  localparam int unsigned CLEAR_SAMPLE_DIV = 4;

  typedef enum logic [2:0] {
    EV_NONE, EV_TAG, EV_BRANCH, EV_MISPRED, EV_FP, EV_FLUSH, EV_INSTR
  } event_kind_t;

endpackage

// ===== flush_sampler.sv
// flush_sampler: turns the pipeline-clearing level into a sampled pulse and an edge pulse
// assumes i_clearing is synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none
module flush_sampler #(
  parameter int unsigned DIV = retire_sel_pkg::CLEAR_SAMPLE_DIV
) (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // clearing level
  input  wire logic i_clearing,
  // pulses
  output logic      o_sample,
  output logic      o_rise
);
  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  localparam int unsigned DW = (DIV > 1) ? $clog2(DIV) : 1;
  initial begin
    if (DIV < 1) $error("flush_sampler: DIV must be at least 1");
  end
  localparam logic [DW-1:0] LAST = DW'(DIV - 1);

  logic [DW-1:0] div_q;
  logic          prev_q;
  wire  logic    at_last = (div_q == LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_q  <= '0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_clearing;
      div_q  <= (!i_clearing || at_last) ? '0 : DW'(div_q + 1'b1);
    end
  end

  // a portion of the clearing cycles: one in DIV
  assign o_sample = i_clearing && at_last;
  assign o_rise   = i_clearing && !prev_q;
endmodule // flush_sampler
`default_nettype wire

// ===== event_match.sv
// event_match: decodes one configuration/control pair into an increment amount
// assumes all retirement inputs belong to the current cycle
`timescale 1ns/1ps
`default_nettype none
module event_match (
  // selected configuration and control words
  input  wire logic [31:0]                   i_cfg,
  input  wire logic [31:0]                   i_ctl,
  // retirement events
  input  wire logic                          i_br_valid,
  input  wire logic                          i_br_taken,
  input  wire logic                          i_br_mispred,
  input  wire logic                          i_br_bogus,
  input  wire logic                          i_fp_valid,
  input  wire logic [4:0]                    i_fp_type,
  input  wire logic                          i_clear_sample,
  input  wire logic                          i_clear_rise,
  input  wire logic                          i_clear_mem,
  input  wire logic                          i_clear_smc,
  input  wire logic [retire_sel_pkg::CNT_W-1:0] i_valid_cnt,
  input  wire logic [retire_sel_pkg::CNT_W-1:0] i_bogus_cnt,
  // results
  output retire_sel_pkg::event_kind_t        o_kind,
  output logic [retire_sel_pkg::AMT_W-1:0]   o_amount,
  output logic                               o_tag_load,
  output logic                               o_tag_store
);
  // ---------------------------------------------------------------
  // field decode
  // ---------------------------------------------------------------
  wire logic [6:0]  code = i_cfg[retire_sel_pkg::CODE_HI:retire_sel_pkg::CODE_LO]; // RL13
  wire logic [15:0] mask = i_cfg[retire_sel_pkg::MASK_HI:retire_sel_pkg::MASK_LO]; // RL13
  wire logic [2:0]  sel  = i_ctl[retire_sel_pkg::SEL_HI:retire_sel_pkg::SEL_LO];   // RL13
  wire logic        en   = i_ctl[retire_sel_pkg::EN_BIT];
  wire logic        edge_mode = i_ctl[retire_sel_pkg::EDGE_BIT];

  // both codes must name the same event
  wire logic is_tag  = (code == retire_sel_pkg::CODE_TAG) && (sel == retire_sel_pkg::SEL_TAG); // RL14
  wire logic is_br   = (code == retire_sel_pkg::CODE_BRANCH) && (sel == retire_sel_pkg::SEL_RET5);
  wire logic is_mp   = (code == retire_sel_pkg::CODE_MISPRED) && (sel == retire_sel_pkg::SEL_RET4);
  wire logic is_fp   = (code == retire_sel_pkg::CODE_FP) && (sel == retire_sel_pkg::SEL_RET5);
  wire logic is_fl   = (code == retire_sel_pkg::CODE_FLUSH) && (sel == retire_sel_pkg::SEL_RET5);
  wire logic is_ins  = (code == retire_sel_pkg::CODE_INSTR) && (sel == retire_sel_pkg::SEL_RET4);

  // ---------------------------------------------------------------
  // per-event hits
  // ---------------------------------------------------------------
  wire logic br_hit = i_br_valid && (                                      // RL3
    (mask[retire_sel_pkg::MB_NT_PRED]    && !i_br_taken && !i_br_mispred) ||
    (mask[retire_sel_pkg::MB_NT_MISPRED] && !i_br_taken &&  i_br_mispred) ||
    (mask[retire_sel_pkg::MB_TK_PRED]    &&  i_br_taken && !i_br_mispred) ||
    (mask[retire_sel_pkg::MB_TK_MISPRED] &&  i_br_taken &&  i_br_mispred));
  wire logic mp_hit = i_br_valid && i_br_mispred &&
                      !(mask[retire_sel_pkg::MB_VALID_PATH] && i_br_bogus); // RL5
  wire logic fp_hit = i_fp_valid &&
                      |(mask[retire_sel_pkg::MB_FP_HI:retire_sel_pkg::MB_FP_LO] & i_fp_type); // RL6 RL7
  wire logic any_tick = edge_mode ? i_clear_rise : i_clear_sample;          // RL9
  wire logic fl_hit = (mask[retire_sel_pkg::MB_FLUSH_ANY] && any_tick) ||   // RL8
                      (mask[retire_sel_pkg::MB_FLUSH_MEM] && i_clear_mem) || // RL10
                      (mask[retire_sel_pkg::MB_FLUSH_SMC] && i_clear_smc);   // RL11
  wire logic [retire_sel_pkg::AMT_W-1:0] ins_amt =                          // RL12
    (mask[retire_sel_pkg::MB_VALID_PATH] ? {1'b0, i_valid_cnt} : '0) +
    (mask[retire_sel_pkg::MB_BOGUS_PATH] ? {1'b0, i_bogus_cnt} : '0);
  wire logic one_hit = (is_br && br_hit) || (is_mp && mp_hit) ||
                       (is_fp && fp_hit) || (is_fl && fl_hit);

  // ---------------------------------------------------------------
  // results
  // ---------------------------------------------------------------
  assign o_kind = is_tag ? retire_sel_pkg::EV_TAG :
                  is_br  ? retire_sel_pkg::EV_BRANCH :
                  is_mp  ? retire_sel_pkg::EV_MISPRED :
                  is_fp  ? retire_sel_pkg::EV_FP :
                  is_fl  ? retire_sel_pkg::EV_FLUSH :
                  is_ins ? retire_sel_pkg::EV_INSTR : retire_sel_pkg::EV_NONE;
  // the tag event never adds to a count
  assign o_amount = !en ? '0 :                                              // RL2
                    is_ins ? ins_amt :
                    {{(retire_sel_pkg::AMT_W-1){1'b0}}, one_hit};
  assign o_tag_load  = en && is_tag && mask[retire_sel_pkg::MB_MARK_LOAD];  // RL1
  assign o_tag_store = en && is_tag && mask[retire_sel_pkg::MB_MARK_STORE]; // RL1
endmodule // event_match
`default_nettype wire

// ===== retirement_event_selector.sv
// retirement_event_selector: register file, counter routing and increment strobes
// assumes retirement inputs are synchronous to I_CORE_CLK and the counters live outside
//
// Behaviour
// RL1 - with the tag event selected, mask bit 1 marks load micro-ops and bit 2 store micro-ops.
// RL2 - the load and store marking bits only tag micro-ops and never increment a counter.
// RL3 - the branch event counts retired branches matching any enabled outcome bit 0 to 3.
// RL4 - the first register of a pair drives counters 12, 13, 16, the second 14, 15, 17.
// RL5 - the mispredicted-branch event counts mispredicted branches, bit 0 keeps valid ones only.
// RL6 - the float assist event counts retired float instructions of any enabled assist type.
// RL7 - assist mask bits 0 to 4 are stack underflow, stack overflow, output overflow, output underflow, input.
// RL8 - the flush event counts by its enabled cause while the whole pipeline is cleared.
// RL9 - flush bit 0 counts a portion of clearing cycles, or occurrences with edge mode.
// RL10 - flush bit 2 counts once per clear due to memory ordering.
// RL11 - flush bit 6 counts once per clear due to self-modifying code.
// RL12 - the completed-instruction event adds valid-path and bogus-path completions per cycle.
// RL13 - event code is config bits 31:25, mask 24:9, select is control bits 15:13.
// RL14 - a counter only increments when code and select name the same defined event.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none
module retirement_event_selector #(
  parameter int unsigned SAMPLE_DIV = retire_sel_pkg::CLEAR_SAMPLE_DIV
) (
  // clock and reset
  input  wire logic                              I_CORE_CLK,
  input  wire logic                              I_RESET_N,
  // register port
  input  wire logic [retire_sel_pkg::ADDR_W-1:0] I_REG_ADDR,
  input  wire logic [31:0]                       I_REG_WDATA,
  input  wire logic                              I_REG_WR,
  input  wire logic                              I_REG_RD,
  output logic      [31:0]                       O_REG_RDATA,
  // branch retirement
  input  wire logic                              I_BR_VALID,
  input  wire logic                              I_BR_TAKEN,
  input  wire logic                              I_BR_MISPRED,
  input  wire logic                              I_BR_BOGUS,
  // float assist retirement
  input  wire logic                              I_FP_VALID,
  input  wire logic [4:0]                        I_FP_TYPE,
  // pipeline clears
  input  wire logic                              I_CLEARING,
  input  wire logic                              I_CLEAR_MEM,
  input  wire logic                              I_CLEAR_SMC,
  // completed instructions
  input  wire logic [retire_sel_pkg::CNT_W-1:0]  I_VALID_DONE,
  input  wire logic [retire_sel_pkg::CNT_W-1:0]  I_BOGUS_DONE,
  // micro-op tagging
  input  wire logic                              I_UOP_VALID,
  input  wire logic                              I_UOP_LOAD,
  input  wire logic                              I_UOP_STORE,
  output logic                                   O_UOP_TAG,
  // increments for counters 12 to 17, counter 12 lowest
  output logic [retire_sel_pkg::NUM_CNT*retire_sel_pkg::AMT_W-1:0] O_CNT_INC
);
  localparam int unsigned NC = retire_sel_pkg::NUM_CNT;
  localparam int unsigned NG = retire_sel_pkg::NUM_CFG;
  localparam int unsigned AW = retire_sel_pkg::AMT_W;

  initial begin
    if (SAMPLE_DIV < 1) $error("retirement_event_selector: SAMPLE_DIV must be at least 1");
  end

  // ---------------------------------------------------------------
  // register decode and storage
  // ---------------------------------------------------------------
  logic [31:0] cfg_q [NG];
  logic [31:0] ctl_q [NC];
  logic [31:0] rd_chain [NG+NC+1];
  logic [31:0] status;
  logic [31:0] rdata_q;
  logic [NC-1:0] defined;

  assign rd_chain[0] = '0;

  for (genvar g = 0; g < NG; g++) begin : g_cfg
    wire logic hit = (I_REG_ADDR ==
                      8'(retire_sel_pkg::OFS_CFG_BASE + 8'(g) * retire_sel_pkg::REG_STRIDE));
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        cfg_q[g] <= retire_sel_pkg::CFG_RESET;
      end else if (I_REG_WR && hit) begin
        cfg_q[g] <= I_REG_WDATA;
      end
    end
    assign rd_chain[g+1] = rd_chain[g] | (hit ? cfg_q[g] : 32'h0000_0000);
  end

  for (genvar c = 0; c < NC; c++) begin : g_ctl
    wire logic hit = (I_REG_ADDR ==
                      8'(retire_sel_pkg::OFS_CTL_BASE + 8'(c) * retire_sel_pkg::REG_STRIDE));
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        ctl_q[c] <= retire_sel_pkg::CTL_RESET;
      end else if (I_REG_WR && hit) begin
        ctl_q[c] <= I_REG_WDATA;
      end
    end
    assign rd_chain[NG+c+1] = rd_chain[NG+c] | (hit ? ctl_q[c] : 32'h0000_0000);
  end

  // status: which counters hold a defined event, and the clearing level
  assign status = {23'h00_0000, I_CLEARING, 2'b00, defined};

  wire logic        stat_hit = (I_REG_ADDR == retire_sel_pkg::OFS_STATUS);
  wire logic [31:0] rd_mux   = rd_chain[NG+NC] | (stat_hit ? status : 32'h0000_0000);

  // unmapped addresses read as zero
  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= I_REG_RD ? rd_mux : 32'h0000_0000;
    end
  end
  assign O_REG_RDATA = rdata_q;

  // ---------------------------------------------------------------
  // pipeline clear pulses
  // ---------------------------------------------------------------
  logic clear_sample;
  logic clear_rise;

  flush_sampler #(
    .DIV        (SAMPLE_DIV)
  ) u_flush (
    .i_clk      (I_CORE_CLK),
    .i_rst_n    (I_RESET_N),
    .i_clearing (I_CLEARING),
    .o_sample   (clear_sample),
    .o_rise     (clear_rise)
  );

  // ---------------------------------------------------------------
  // per-counter selection and matching
  // ---------------------------------------------------------------
  logic [31:0]                 sel_cfg [NC];
  retire_sel_pkg::event_kind_t kind [NC];
  logic [AW-1:0]               amt [NC];
  logic [AW-1:0]               inc_q [NC];
  logic [NC-1:0]               tag_ld;
  logic [NC-1:0]               tag_st;

  for (genvar c = 0; c < NC; c++) begin : g_cnt
    // pair bit picks a/b or c/d, fixed position picks first or second
    wire logic [1:0] cfg_idx = {ctl_q[c][retire_sel_pkg::PAIR_BIT],
                                retire_sel_pkg::SECOND_OF_PAIR[c]};     // RL4
    assign sel_cfg[c] = cfg_q[cfg_idx];                                 // RL4
    assign defined[c] = (kind[c] != retire_sel_pkg::EV_NONE);          // RL14

    event_match u_match (
      .i_cfg          (sel_cfg[c]),
      .i_ctl          (ctl_q[c]),
      .i_br_valid     (I_BR_VALID),
      .i_br_taken     (I_BR_TAKEN),
      .i_br_mispred   (I_BR_MISPRED),
      .i_br_bogus     (I_BR_BOGUS),
      .i_fp_valid     (I_FP_VALID),
      .i_fp_type      (I_FP_TYPE),
      .i_clear_sample (clear_sample),
      .i_clear_rise   (clear_rise),
      .i_clear_mem    (I_CLEAR_MEM),
      .i_clear_smc    (I_CLEAR_SMC),
      .i_valid_cnt    (I_VALID_DONE),
      .i_bogus_cnt    (I_BOGUS_DONE),
      .o_kind         (kind[c]),
      .o_amount       (amt[c]),
      .o_tag_load     (tag_ld[c]),
      .o_tag_store    (tag_st[c])
    );

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
        inc_q[c] <= '0;
      end else begin
        inc_q[c] <= amt[c];                                             // RL14
      end
    end
    assign O_CNT_INC[c*AW +: AW] = inc_q[c];
  end

  // ---------------------------------------------------------------
  // micro-op tagging
  // ---------------------------------------------------------------
  logic tag_q;
  wire  logic tag_d = I_UOP_VALID && ((I_UOP_LOAD && |tag_ld) ||
                                      (I_UOP_STORE && |tag_st));        // RL1

  always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tag_q <= 1'b0;
    end else begin
      tag_q <= tag_d;
    end
  end
  assign O_UOP_TAG = tag_q;

  // ---------------------------------------------------------------
  // checks on counter 12, and one routing check on counter 14
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RESET_N);

  wire logic [15:0] m0  = sel_cfg[0][retire_sel_pkg::MASK_HI:retire_sel_pkg::MASK_LO];
  wire logic        en0 = ctl_q[0][retire_sel_pkg::EN_BIT];

  a_tag_marks_load: // RL1
    assert property (I_UOP_VALID && I_UOP_LOAD && tag_ld[0] |=> O_UOP_TAG)
    else $error("load micro-op not tagged");

  a_tag_no_count: // RL2
    assert property (kind[0] == retire_sel_pkg::EV_TAG |=> inc_q[0] == '0)
    else $error("tag event incremented a counter");

  a_branch_count: // RL3
    assert property (kind[0] == retire_sel_pkg::EV_BRANCH && en0 && I_BR_VALID
                     && I_BR_TAKEN && !I_BR_MISPRED && m0[retire_sel_pkg::MB_TK_PRED]
                     |=> inc_q[0] == AW'(1))
    else $error("taken predicted branch not counted");

  a_pair_routing: // RL4
    assert property (!ctl_q[0][retire_sel_pkg::PAIR_BIT] && cfg_q[0] == '0
                     |=> inc_q[0] == '0)
    else $error("counter 12 driven by a foreign register");

  a_second_route: // RL4
    assert property (ctl_q[2][retire_sel_pkg::PAIR_BIT] && cfg_q[3] == '0
                     |=> O_CNT_INC[2*AW +: AW] == '0)
    else $error("counter 14 driven by a foreign register");

  a_mispred_valid: // RL5
    assert property (kind[0] == retire_sel_pkg::EV_MISPRED
                     && m0[retire_sel_pkg::MB_VALID_PATH] && I_BR_BOGUS
                     |=> inc_q[0] == '0)
    else $error("bogus mispredicted branch counted");

  a_fp_assist: // RL6
    assert property (kind[0] == retire_sel_pkg::EV_FP && en0 && I_FP_VALID
                     && |(m0[4:0] & I_FP_TYPE) |=> inc_q[0] == AW'(1))
    else $error("float assist not counted");

  a_fp_type_off: // RL7
    assert property (kind[0] == retire_sel_pkg::EV_FP && (m0[4:0] & I_FP_TYPE) == 5'h00
                     |=> inc_q[0] == '0)
    else $error("disabled assist type counted");

  a_flush_edge: // RL9
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH
                     && ctl_q[0][retire_sel_pkg::EDGE_BIT] && m0 == 16'h0001
                     && I_CLEARING && $past(I_CLEARING) && $past(I_RESET_N)
                     |=> inc_q[0] == '0)
    else $error("edge mode counted a held clear");

  a_flush_mem: // RL10
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH && en0 && m0 == 16'h0004
                     && I_CLEAR_MEM |=> inc_q[0] == AW'(1))
    else $error("memory ordering clear not counted");

  a_flush_smc: // RL11
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH && en0 && m0 == 16'h0040
                     ##0 !I_CLEAR_SMC |=> inc_q[0] == '0)
    else $error("self-modify count without a clear");

  a_flush_held: // RL8
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH && en0 && m0 == 16'h0001
                     && !ctl_q[0][retire_sel_pkg::EDGE_BIT] && !I_CLEARING
                     |=> inc_q[0] == '0)
    else $error("flush counted outside a clear");

  a_instr_sum: // RL12
    assert property (kind[0] == retire_sel_pkg::EV_INSTR && en0 && m0[1:0] == 2'b11
                     |=> inc_q[0] == AW'($past(I_VALID_DONE)) + AW'($past(I_BOGUS_DONE)))
    else $error("completed instruction sum wrong");

  a_read_config: // RL13
    assert property (I_REG_RD && I_REG_ADDR == retire_sel_pkg::OFS_CFG_BASE && !I_REG_WR
                     |=> O_REG_RDATA == $past(cfg_q[0]))
    else $error("config read data wrong");

  a_mismatch_zero: // RL14
    assert property (!defined[0] |=> inc_q[0] == '0)
    else $error("undefined combination incremented");

  a_mem_off: // RL10
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH && m0 == 16'h0004 && !I_CLEAR_MEM
                     |=> inc_q[0] == '0)
    else $error("memory ordering count without a clear");

  a_flush_rise: // RL9
    assert property (kind[0] == retire_sel_pkg::EV_FLUSH && en0 && m0 == 16'h0001
                     && ctl_q[0][retire_sel_pkg::EDGE_BIT] && clear_rise
                     |=> inc_q[0] == AW'(1))
    else $error("edge mode missed a clear");

  a_instr_valid: // RL12
    assert property (kind[0] == retire_sel_pkg::EV_INSTR && en0 && m0[1:0] == 2'b01
                     |=> inc_q[0] == AW'($past(I_VALID_DONE)))
    else $error("valid completions wrong");

  a_disabled_zero: // RL14
    assert property (!en0 |=> inc_q[0] == '0)
    else $error("disabled counter counted");

  // ---------------------------------------------------------------
  // register port and tag checks
  // ---------------------------------------------------------------
  a_rdata_idle: // RL13
    assert property (!I_REG_RD |=> O_REG_RDATA == '0)
    else $error("read data outside a read");

  a_ctl_read: // RL13
    assert property (I_REG_RD && I_REG_ADDR == retire_sel_pkg::OFS_CTL_BASE
                     |=> O_REG_RDATA == $past(ctl_q[0]))
    else $error("control read wrong");

  a_stat_clear: // RL8
    assert property (I_REG_RD && stat_hit && I_CLEARING
                     |=> O_REG_RDATA[retire_sel_pkg::STAT_CLEARING_BIT])
    else $error("status lost the clear");

  a_store_tag: // RL1
    assert property (I_UOP_VALID && I_UOP_STORE && tag_st[0] |=> O_UOP_TAG)
    else $error("store not tagged");

  a_tag_idle: // RL1
    assert property (!I_UOP_VALID |=> !O_UOP_TAG)
    else $error("tag without a micro-op");

  c_branch_count:
    cover property (kind[0] == retire_sel_pkg::EV_BRANCH ##1 inc_q[0] != '0);
  c_flush_edge:
    cover property (kind[0] == retire_sel_pkg::EV_FLUSH && clear_rise ##1 inc_q[0] != '0);
  c_uop_tag:
    cover property (tag_d ##1 O_UOP_TAG);
  c_instr_two:
    cover property (kind[0] == retire_sel_pkg::EV_INSTR ##1 inc_q[0] >= AW'(2));
  c_flush_smc:
    cover property (I_CLEAR_SMC ##1 inc_q[0] != '0);

endmodule // retirement_event_selector
`default_nettype wire

// ===== retirement_event_selector_bench.sv
// self-checking bench for retirement_event_selector
// assumes retire_sel_pkg and the design files are compiled first
`timescale 1ns/1ps
`default_nettype none
module retirement_event_selector_bench;
  logic        clk, rst_n, wr, rd, bv, bt, bm, bb, fv, cl, clm, cls, uv, ul, us, tag;
  logic [7:0]  addr;
  logic [31:0] wd, rdata;
  logic [4:0]  ft;
  logic [1:0]  vd, bd;
  logic [17:0] inc;
  int          bad_count, cmp_count;
  retirement_event_selector #(.SAMPLE_DIV(1)) dut (
    .I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_REG_ADDR(addr), .I_REG_WDATA(wd),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_BR_VALID(bv), .I_BR_TAKEN(bt),
    .I_BR_MISPRED(bm), .I_BR_BOGUS(bb), .I_FP_VALID(fv), .I_FP_TYPE(ft), .I_CLEARING(cl),
    .I_CLEAR_MEM(clm), .I_CLEAR_SMC(cls), .I_VALID_DONE(vd), .I_BOGUS_DONE(bd),
    .I_UOP_VALID(uv), .I_UOP_LOAD(ul), .I_UOP_STORE(us), .O_UOP_TAG(tag), .O_CNT_INC(inc));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= w; rd <= !w;
    @(posedge clk);
    wr <= 0; rd <= 0;
    #1;
  endtask
  // one event cycle: drive before calling, then check increments and tag
  task automatic step(input logic [17:0] e, input logic t);
    @(posedge clk);
    {bv, bt, bm, bb, fv, clm, cls, uv, ul, us} <= '0; ft <= '0; vd <= '0; bd <= '0;
    #1 chk(32'(e), 32'(inc));
    chk(32'(t), 32'(tag));
  endtask
  task automatic setup(input logic [7:0] ca, input logic [6:0] c, input logic [15:0] m,
                       input logic [7:0] ta, input logic [2:0] s);
    reg_op(1, ca, {c, m, 9'h000});
    reg_op(1, ta, {16'h0000, s, 1'b1, 12'h000});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    reg_op(1, 8'h04, 32'hA5A5_0000);
    reg_op(0, 8'h04, 32'h0000_0000);
    chk(32'hA5A5_0000, rdata);
    reg_op(0, 8'h3C, 32'h0000_0000);
    chk(32'h0000_0000, rdata);
  endtask
  task automatic t_branch;
    setup(8'h00, 7'h06, 16'h0004, 8'h10, 3'h5);
    @(posedge clk) begin bv <= 1; bt <= 1; end
    step(18'h00001, 0);
    @(posedge clk) bv <= 1;
    step(18'h00000, 0);
    reg_op(1, 8'h10, 32'h0000_9000);
    @(posedge clk) begin bv <= 1; bt <= 1; end
    step(18'h00000, 0);
  endtask
  task automatic t_mispred;
    setup(8'h00, 7'h03, 16'h0001, 8'h10, 3'h4);
    @(posedge clk) begin bv <= 1; bm <= 1; bb <= 1; end
    step(18'h00000, 0);
    @(posedge clk) begin bv <= 1; bm <= 1; end
    step(18'h00001, 0);
  endtask
  task automatic t_float;
    setup(8'h04, 7'h03, 16'h0010, 8'h18, 3'h5);
    @(posedge clk) begin fv <= 1; ft <= 5'h10; end
    step(18'h00040, 0);
    @(posedge clk) begin fv <= 1; ft <= 5'h01; end
    step(18'h00000, 0);
  endtask
  task automatic t_misc;
    setup(8'h00, 7'h07, 16'h0003, 8'h10, 3'h4);
    @(posedge clk) begin vd <= 2'h2; bd <= 2'h1; end
    step(18'h00003, 0);
    setup(8'h00, 7'h02, 16'h0004, 8'h10, 3'h5);
    @(posedge clk) clm <= 1;
    step(18'h00001, 0);
    setup(8'h00, 7'h02, 16'h0002, 8'h10, 3'h2);
    @(posedge clk) begin uv <= 1; ul <= 1; end
    step(18'h00000, 1);
    @(posedge clk) begin uv <= 1; us <= 1; end
    step(18'h00000, 0);
  endtask
  task automatic t_flush;
    setup(8'h00, 7'h02, 16'h0001, 8'h10, 3'h5);
    @(posedge clk) cl <= 1;
    step(18'h00001, 0);
    step(18'h00001, 0);
    @(posedge clk) cl <= 0;
    step(18'h00000, 0);
    reg_op(1, 8'h10, 32'h0100_B000);
    @(posedge clk) cl <= 1;
    step(18'h00001, 0);
    step(18'h00000, 0);
    reg_op(0, 8'h28, 32'h0000_0000);
    chk(32'h0000_0105, rdata);
    @(posedge clk) cl <= 0;
    reg_op(1, 8'h00, 32'h0400_8000);
    @(posedge clk) cls <= 1;
    step(18'h00001, 0);
    reg_op(1, 8'h10, 32'h0001_B000);
    @(posedge clk) cls <= 1;
    step(18'h00000, 0);
  endtask
  initial begin
    {rst_n, wr, rd, bv, bt, bm, bb, fv, cl, clm, cls, uv, ul, us} = '0;
    addr = '0; wd = '0; ft = '0; vd = '0; bd = '0;
    bad_count = 0; cmp_count = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    t_regs;
    t_branch;
    t_mispred;
    t_float;
    t_misc;
    t_flush;
    end_sim;
  end
  initial begin
    #5000;
    bad_count++;
    end_sim;
  end
endmodule // retirement_event_selector_bench
`default_nettype wire
